// File: usdb_pkg.sv
package usdb_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_RXL = 6'h00;
    localparam logic [5:0] IDX_RXH = 6'h01;
    localparam logic [5:0] IDX_TXL = 6'h02;
    localparam logic [5:0] IDX_TXH = 6'h03;
    localparam logic [5:0] IDX_STAT = 6'h04;
    localparam logic [5:0] IDX_INTERRUPT_AND_LINE_CONTROL = 6'h05;
    localparam logic [5:0] IDX_ENABLE_AND_RECEIVE_MODE = 6'h06;
    localparam logic [5:0] IDX_FRAME_FORMAT_CONTROL = 6'h07;
    localparam logic [5:0] IDX_BAUD = 6'h08;
    localparam logic [5:0] IDX_DBG = 6'h0B;
    localparam logic [5:0] IDX_EVC = 6'h0C;
    localparam logic [5:0] IDX_TXPL = 6'h0D;
    localparam logic [5:0] IDX_RXPL = 6'h0E;
    localparam logic [5:0] IDX_ISTAT = 6'h10;
    localparam logic [5:0] IDX_IEN = 6'h11;
    localparam logic [5:0] IDX_ICLR = 6'h12;
    // Control field positions
    localparam int RECEIVER_ENABLE_BIT = 7;
    localparam int TXEN_BIT = 6;
    localparam int RXMODE_LSB = 1;
    localparam int CMODE_LSB = 6;
    localparam int PMODE_LSB = 4;
    localparam int CHARACTER_SIZE_FIELD_LSB = 0;
    // Encodings
    localparam logic [1:0] RXMODE_LIN_AUTOMATIC_RECEIVE_MODE = 2'h3;
    localparam logic [1:0] CMODE_MSPI = 2'h3;
    localparam logic [1:0] PMODE_OFF = 2'h0;
    localparam logic [2:0] CH_5 = 3'h0;
    localparam logic [2:0] CH_6 = 3'h1;
    localparam logic [2:0] CH_7 = 3'h2;
    localparam logic [2:0] CH_9L = 3'h6;
    localparam logic [2:0] CH_9H = 3'h7;
    // Receive entry layout
    localparam int E_FRAME_ERROR_BIT = 10;
    localparam int E_PARITY_ERROR_BIT = 9;
    localparam int E_D8 = 8;
    localparam int ENT_W = 11;
    // Interrupt status bits
    localparam int IS_RX = 0;
    localparam int IS_OVF = 1;
    localparam int IS_TXLD = 2;
    localparam int IS_DROP = 3;
    localparam int IS_W = 4;
    // Reset values and bus answers
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] BAUD_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: usdb_top.sv
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module usdb_top #(
    parameter int RX_FIFO_DEPTH = 2,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Receive shifter side
    input wire logic rx_char_valid,
    input wire logic [8:0] rx_char_data,
    input wire logic rx_char_frame_error_bit,
    input wire logic rx_char_parity_error_bit,
    input wire logic rx_lin_pid_parity_error_bit,
    input wire logic rx_lin_resp,
    input wire logic rx_start_det,
    // Transmit shifter side
    input wire logic tx_shifter_empty,
    output logic tx_load,
    output logic [8:0] tx_load_data,
    // Configuration and interrupt
    output logic [7:0] ctrl_a,
    output logic [7:0] ctrl_b,
    output logic [7:0] ctrl_c,
    output logic [15:0] baud_div,
    output logic irq
);
    import usdb_pkg::*;

    // Refuse sizes that the two-slot pointers and the index decode cannot serve
    if (RX_FIFO_DEPTH != 2) begin
        $error("RX_FIFO_DEPTH must be 2");
    end
    if (ADDR_W < 8) begin
        $error("ADDR_W must be at least 8");
    end

    function automatic logic [7:0] size_mask(input logic [2:0] cs);
        size_mask = (cs == CH_5) ? 8'h1F : (cs == CH_6) ? 8'h3F : (cs == CH_7) ? 8'h7F : 8'hFF;
    endfunction

    function automatic logic is_mapped(input logic [5:0] ix);
        is_mapped = (ix <= IDX_BAUD) || (ix >= IDX_DBG && ix <= IDX_RXPL) ||
                    (ix >= IDX_ISTAT && ix <= IDX_ICLR);
    endfunction

    // Bus state
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r, wdata_r, rd_mux;
    logic [ADDR_W-1:0] awaddr_r;
    logic [3:0] wstrb_r;
    // Configuration
    logic [7:0] interrupt_and_line_control_r, enable_and_receive_mode_r, frame_format_control_r, dbg_r, evc_r, txpl_r, rxpl_r;
    logic [15:0] baud_r;
    logic [IS_W-1:0] stat_r, ien_r;
    logic irq_r;
    // Receive path
    logic [ENT_W-1:0] fifo_r [RX_FIFO_DEPTH];
    logic [ENT_W-1:0] hold_r;
    logic hold_v_r, rd_ptr_r, wr_ptr_r, ovf_r;
    logic [1:0] cnt_r;
    // Transmit path
    logic [7:0] txbuf_r;
    logic tx9_r, dre_r, tx_full_r, tx_lo_got_r, tx_load_r;
    logic [8:0] tx_load_data_r;

    // Mode decode
    wire receiver_enable = enable_and_receive_mode_r[RECEIVER_ENABLE_BIT];
    wire txen = enable_and_receive_mode_r[TXEN_BIT];
    wire [2:0] character_size_field = frame_format_control_r[CHARACTER_SIZE_FIELD_LSB +: 3];
    wire lowfirst = (character_size_field == CH_9L);
    wire is9 = (character_size_field == CH_9L) || (character_size_field == CH_9H);
    wire lin_automatic_receive_mode = (enable_and_receive_mode_r[RXMODE_LSB +: 2] == RXMODE_LIN_AUTOMATIC_RECEIVE_MODE);
    wire mspi = (frame_format_control_r[CMODE_LSB +: 2] == CMODE_MSPI);
    wire par_en = (frame_format_control_r[PMODE_LSB +: 2] != PMODE_OFF);
    wire [7:0] mask = size_mask(character_size_field);

    // Read decode
    wire [5:0] ridx = araddr[7:2];
    wire rd_fire = arvalid && arready_r;
    wire rd_rxl = rd_fire && (ridx == IDX_RXL);
    wire rd_rxh = rd_fire && (ridx == IDX_RXH);

    // Write decode
    wire [5:0] widx = awaddr_r[7:2];
    wire wr_do = !awready_r && !wready_r && !bvalid_r;
    wire wr_lo = wr_do && wstrb_r[0];
    wire wr_hi = wr_do && wstrb_r[1];
    wire txl_wr = wr_lo && (widx == IDX_TXL);
    wire txh_wr = wr_lo && (widx == IDX_TXH);
    wire txl_take = txl_wr && dre_r;
    wire txl_drop = txl_wr && !dre_r;
    wire [IS_W-1:0] iclr = (wr_lo && widx == IDX_ICLR) ? wdata_r[IS_W-1:0] : '0;

    // Receive entry formation
    wire rxv = rx_char_valid && receiver_enable;
    wire parity_error_bit_in = lin_automatic_receive_mode ? rx_lin_pid_parity_error_bit : (par_en && rx_char_parity_error_bit);
    wire d8_in = lin_automatic_receive_mode ? rx_lin_resp : rx_char_data[8];
    wire [ENT_W-1:0] new_ent = {rx_char_frame_error_bit, parity_error_bit_in, d8_in, rx_char_data[7:0]};
    // Empty buffer shows zero data and flags, not a stale or unwritten slot
    wire [ENT_W-1:0] head = (cnt_r != 2'h0) ? fifo_r[rd_ptr_r] : '0;

    // FIFO movement
    wire pop = (cnt_r != 2'h0) && (lowfirst ? rd_rxh : rd_rxl);
    wire space = (cnt_r != 2'h2) || pop;
    wire push_hold = hold_v_r && space;
    wire push_new = rxv && space && !hold_v_r;
    wire to_hold = rxv && !push_new && (!hold_v_r || push_hold);
    wire push = push_hold || push_new;
    wire [ENT_W-1:0] push_ent = hold_v_r ? hold_r : new_ent;
    wire [1:0] cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
    wire ovf_set = receiver_enable && (cnt_r == 2'h2) && hold_v_r && rx_start_det;

    // Transmit movement
    wire tx_go = tx_full_r && txen && tx_shifter_empty && !tx_load_r;
    wire [IS_W-1:0] ev = {txl_drop, tx_go, ovf_set, push};

    // Receive high byte view
    wire receive_complete_flag = (cnt_r != 2'h0);
    wire [7:0] rxh_view = {receive_complete_flag, ovf_r && !mspi, 3'h0, head[E_FRAME_ERROR_BIT] && !mspi,
                           head[E_PARITY_ERROR_BIT] && !mspi, head[E_D8] && (is9 || lin_automatic_receive_mode)};

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (ridx)
            IDX_RXL: rd_mux[7:0] = head[7:0] & mask;
            IDX_RXH: rd_mux[7:0] = rxh_view;
            IDX_TXL: rd_mux[7:0] = txbuf_r;
            IDX_STAT: rd_mux[7:0] = {receive_complete_flag, 1'b0, dre_r, 5'h00};
            IDX_INTERRUPT_AND_LINE_CONTROL: rd_mux[7:0] = interrupt_and_line_control_r;
            IDX_ENABLE_AND_RECEIVE_MODE: rd_mux[7:0] = enable_and_receive_mode_r;
            IDX_FRAME_FORMAT_CONTROL: rd_mux[7:0] = frame_format_control_r;
            IDX_BAUD: rd_mux[15:0] = baud_r;
            IDX_DBG: rd_mux[7:0] = dbg_r;
            IDX_EVC: rd_mux[7:0] = evc_r;
            IDX_TXPL: rd_mux[7:0] = txpl_r;
            IDX_RXPL: rd_mux[7:0] = rxpl_r;
            IDX_ISTAT: rd_mux[IS_W-1:0] = stat_r;
            IDX_IEN: rd_mux[IS_W-1:0] = ien_r;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Write channel handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (awvalid && awready_r) begin
                awready_r <= 1'b0;
                awaddr_r <= awaddr;
            end
            if (wvalid && wready_r) begin
                wready_r <= 1'b0;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (wr_do) begin
                bvalid_r <= 1'b1;
                bresp_r <= is_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_r && bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (rd_fire) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // Configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_and_line_control_r <= CTRL_RST;
            enable_and_receive_mode_r <= CTRL_RST;
            frame_format_control_r <= CTRL_RST;
            dbg_r <= CTRL_RST;
            evc_r <= CTRL_RST;
            txpl_r <= CTRL_RST;
            rxpl_r <= CTRL_RST;
            baud_r <= BAUD_RST;
            ien_r <= '0;
        end else begin
            if (wr_lo && widx == IDX_INTERRUPT_AND_LINE_CONTROL) interrupt_and_line_control_r <= wdata_r[7:0];
            if (wr_lo && widx == IDX_ENABLE_AND_RECEIVE_MODE) enable_and_receive_mode_r <= wdata_r[7:0];
            if (wr_lo && widx == IDX_FRAME_FORMAT_CONTROL) frame_format_control_r <= wdata_r[7:0];
            if (wr_lo && widx == IDX_DBG) dbg_r <= wdata_r[7:0];
            if (wr_lo && widx == IDX_EVC) evc_r <= wdata_r[7:0];
            if (wr_lo && widx == IDX_TXPL) txpl_r <= wdata_r[7:0];
            if (wr_lo && widx == IDX_RXPL) rxpl_r <= wdata_r[7:0];
            if (wr_lo && widx == IDX_BAUD) baud_r[7:0] <= wdata_r[7:0];
            if (wr_hi && widx == IDX_BAUD) baud_r[15:8] <= wdata_r[15:8];
            if (wr_lo && widx == IDX_IEN) ien_r <= wdata_r[IS_W-1:0];
        end
    end

    // Receive FIFO, shifter hold slot and overflow
    always_ff @(posedge aclk) begin
        if (!aresetn || !receiver_enable) begin
            cnt_r <= 2'h0;
            rd_ptr_r <= 1'b0;
            wr_ptr_r <= 1'b0;
            hold_v_r <= 1'b0;
            hold_r <= '0;
            ovf_r <= 1'b0;
        end else begin
            if (push) fifo_r[wr_ptr_r] <= push_ent;
            wr_ptr_r <= wr_ptr_r ^ push;
            rd_ptr_r <= rd_ptr_r ^ pop;
            cnt_r <= cnt_nxt;
            if (to_hold) begin
                hold_v_r <= 1'b1;
                hold_r <= new_ent;
            end else if (push_hold) begin
                hold_v_r <= 1'b0;
            end
            if (ovf_set) ovf_r <= 1'b1;
            else if (rd_rxl) ovf_r <= 1'b0;
        end
    end

    // Transmit buffer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dre_r <= 1'b1;
            txbuf_r <= 8'h00;
            tx9_r <= 1'b0;
            tx_full_r <= 1'b0;
            tx_lo_got_r <= 1'b0;
            tx_load_r <= 1'b0;
            tx_load_data_r <= 9'h000;
        end else begin
            tx_load_r <= tx_go;
            if (tx_go) tx_load_data_r <= {tx9_r && is9, txbuf_r & mask};
            if (txh_wr) tx9_r <= wdata_r[0];
            if (txl_take) begin
                txbuf_r <= wdata_r[7:0];
                dre_r <= 1'b0;
            end else if (tx_go) begin
                dre_r <= 1'b1;
            end
            if (txl_take && lowfirst) tx_lo_got_r <= 1'b1;
            else if (txh_wr) tx_lo_got_r <= 1'b0;
            if ((txl_take && !lowfirst) || (txh_wr && tx_lo_got_r)) tx_full_r <= 1'b1;
            else if (tx_go) tx_full_r <= 1'b0;
        end
    end

    // Interrupt status, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= '0;
            irq_r <= 1'b0;
        end else begin
            stat_r <= (stat_r & ~iclr) | ev;
            irq_r <= |(stat_r & ien_r);
        end
    end

    assign awready = awready_r;
    assign wready = wready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign tx_load = tx_load_r;
    assign tx_load_data = tx_load_data_r;
    assign ctrl_a = interrupt_and_line_control_r;
    assign ctrl_b = enable_and_receive_mode_r;
    assign ctrl_c = frame_format_control_r;
    assign baud_div = baud_r;
    assign irq = irq_r;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_rx_flush: assert property (!receiver_enable |=> cnt_r == 2'h0 && !hold_v_r)
        else $error("receive buffer not flushed");
    a_err_clear: assert property (!receiver_enable |=> !ovf_r)
        else $error("overflow survives receiver disable");
    a_ovf_set: assert property (ovf_set |=> ovf_r ##1
        (ovf_r || $past(rd_rxl) || !$past(receiver_enable)))
        else $error("overflow not set");
    a_ovf_hold: assert property (ovf_r && !rd_rxl && receiver_enable |=> ovf_r)
        else $error("overflow lost before low byte read");
    a_tx_gate: assert property (txl_drop && !tx_go |=> $stable(txbuf_r) && !dre_r)
        else $error("transmit write taken while buffer busy");
    a_dre_set: assert property (tx_go |=> dre_r)
        else $error("empty flag not set on shifter load");
    a_tx_mask: assert property (tx_go |=> (tx_load_data[7:0] & ~$past(mask)) == 8'h00)
        else $error("unused transmit bits not dropped");
    a_spi_quiet: assert property (rd_rxh && mspi |=> rdata[6:1] == 6'h00)
        else $error("error bits shown in spi master mode");
    a_empty_view: assert property (rd_rxh && cnt_r == 2'h0 |=> !rdata[7] && rdata[2:0] == 3'h0)
        else $error("empty buffer shows data flags");
    a_irq_level: assert property (|(stat_r & ien_r) |=> irq)
        else $error("interrupt not raised");
    a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    a_dre_clear: assert property (txl_take |=> !dre_r)
        else $error("empty flag not cleared");
    a_tx_load: assert property (tx_go |=> tx_load && !tx_full_r ##1 !tx_load)
        else $error("transmit load sequence wrong");
    a_fifo_pop: assert property (pop && !push && receiver_enable |=> cnt_r == $past(cnt_r) - 2'h1)
        else $error("fifo did not advance");
    a_parity_error_bit_off: assert property (push_new && !par_en && !lin_automatic_receive_mode |-> !new_ent[E_PARITY_ERROR_BIT])
        else $error("parity error without checking");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");

    c_overflow: cover property (ovf_set);
    c_lowfirst_pop: cover property (lowfirst && pop);
    c_tx_load: cover property (tx_go ##1 tx_load);
    c_irq: cover property (irq);
    c_lin_pid: cover property (lin_automatic_receive_mode && push_new && !d8_in);
endmodule

// File: usdb_line_model.sv
`timescale 1ns/1ps
module usdb_line_model (
    // Clock
    input wire logic aclk,
    // Receive shifter side
    output logic rx_char_valid,
    output logic [8:0] rx_char_data,
    output logic rx_char_frame_error_bit,
    output logic rx_char_parity_error_bit,
    output logic rx_lin_pid_parity_error_bit,
    output logic rx_lin_resp,
    output logic rx_start_det,
    // Transmit shifter side
    output logic tx_shifter_empty,
    input wire logic tx_load,
    input wire logic [8:0] tx_load_data
);
    logic hold_busy = 1'b0;
    logic [8:0] last_tx = 9'h000;
    int n_tx = 0;
    int busy_cnt = 0;

    initial begin
        {rx_char_valid, rx_char_data, rx_char_frame_error_bit, rx_char_parity_error_bit} = '0;
        {rx_lin_pid_parity_error_bit, rx_lin_resp, rx_start_det} = '0;
    end

    // One received character; lines show junk once the pulse is over
    task automatic send(input logic [8:0] d, input logic [3:0] f);
        @(posedge aclk);
        rx_char_valid <= 1'b1;
        rx_char_data <= d;
        {rx_char_frame_error_bit, rx_char_parity_error_bit, rx_lin_pid_parity_error_bit, rx_lin_resp} <= f;
        @(posedge aclk);
        rx_char_valid <= 1'b0;
        rx_char_data <= ~d;
        {rx_char_frame_error_bit, rx_char_parity_error_bit, rx_lin_pid_parity_error_bit, rx_lin_resp} <= ~f;
    endtask

    task automatic start();
        @(posedge aclk);
        rx_start_det <= 1'b1;
        @(posedge aclk);
        rx_start_det <= 1'b0;
    endtask

    // Shifter stays busy for a frame after each load
    always @(posedge aclk) begin
        if (tx_load) begin
            last_tx <= tx_load_data;
            n_tx <= n_tx + 1;
            busy_cnt <= 8;
        end else if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
        end
    end
    assign tx_shifter_empty = (busy_cnt == 0) && !hold_busy;
endmodule

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import usdb_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic rcv, rfe, rpe, rpid, rrsp, rsd, tse, tld;
    logic [8:0] rcd, tldd;
    logic [7:0] ctrl_a, ctrl_b, ctrl_c;
    logic [15:0] baud_div;
    logic [31:0] rd_v;
    logic [1:0] rd_r;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    usdb_top usdb_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rx_char_valid(rcv), .rx_char_data(rcd), .rx_char_frame_error_bit(rfe), .rx_char_parity_error_bit(rpe),
        .rx_lin_pid_parity_error_bit(rpid), .rx_lin_resp(rrsp), .rx_start_det(rsd),
        .tx_shifter_empty(tse), .tx_load(tld), .tx_load_data(tldd), .ctrl_a(ctrl_a),
        .ctrl_b(ctrl_b), .ctrl_c(ctrl_c), .baud_div(baud_div), .irq(irq));

    usdb_line_model usdb_line_model_i (.aclk(aclk), .rx_char_valid(rcv), .rx_char_data(rcd),
        .rx_char_frame_error_bit(rfe), .rx_char_parity_error_bit(rpe), .rx_lin_pid_parity_error_bit(rpid), .rx_lin_resp(rrsp),
        .rx_start_det(rsd), .tx_shifter_empty(tse), .tx_load(tld), .tx_load_data(tldd));

    initial begin
        forever #12.5 aclk = ~aclk;
    end

    task test_done();
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches = mismatches + 1;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [5:0] i, input logic [31:0] d);
        logic a;
        logic w;
        a = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        awaddr <= {i, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (!a && awready) begin
                a = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(a && w));
        do @(posedge aclk); while (!bvalid);
        rd_r = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] i);
        @(posedge aclk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd_v = rdata;
        rd_r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [5:0] i, input logic [31:0] e, input string nm);
        rd(i);
        chk(nm, e, rd_v);
    endtask

    // High byte first, then low byte
    task automatic rxhl(input logic [31:0] h, input logic [31:0] l);
        rchk(IDX_RXH, h, "rx_high");
        rchk(IDX_RXL, l, "rx_low");
    endtask

    task automatic wait_tx(input int n);
        while (usdb_line_model_i.n_tx < n) @(posedge aclk);
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(IDX_STAT, 32'h20, "status");
        rchk(IDX_RXH, 32'h00, "rx_high_rst");
        rd(6'h0A);
        chk("rresp", RESP_SLVERR, rd_r);
        wr(6'h0A, 32'h1);
        chk("bresp", RESP_SLVERR, rd_r);
        wr(IDX_INTERRUPT_AND_LINE_CONTROL, 32'h5A);
        rchk(IDX_INTERRUPT_AND_LINE_CONTROL, 32'h5A, "ctrl_a_reg");
        chk("rresp_ok", RESP_OKAY, rd_r);
        chk("ctrl_a", 32'h5A, ctrl_a);
        wr(IDX_BAUD, 32'h1234);
        chk("bresp_ok", RESP_OKAY, rd_r);
        rchk(IDX_BAUD, 32'h1234, "baud");
        chk("baud_div", 32'h1234, baud_div);
        // Receive with parity checking on
        wr(IDX_ENABLE_AND_RECEIVE_MODE, 32'h80);
        wr(IDX_FRAME_FORMAT_CONTROL, 32'h13);
        chk("ctrl_b", 32'h80, ctrl_b);
        chk("ctrl_c", 32'h13, ctrl_c);
        usdb_line_model_i.send(9'h0A5, 4'b1000);
        usdb_line_model_i.send(9'h03C, 4'b0100);
        rxhl(32'h84, 32'hA5);
        rxhl(32'h82, 32'h3C);
        rchk(IDX_STAT, 32'h20, "status");
        // Two buffered, one waiting, then a new start bit
        usdb_line_model_i.send(9'h011, 4'b0000);
        usdb_line_model_i.send(9'h022, 4'b0000);
        usdb_line_model_i.send(9'h033, 4'b0000);
        usdb_line_model_i.start();
        rxhl(32'hC0, 32'h11);
        rxhl(32'h80, 32'h22);
        rxhl(32'h80, 32'h33);
        wr(IDX_FRAME_FORMAT_CONTROL, 32'h02);
        usdb_line_model_i.send(9'h0FF, 4'b0100);
        rxhl(32'h80, 32'h7F);
        wr(IDX_FRAME_FORMAT_CONTROL, 32'h07);
        usdb_line_model_i.send(9'h1A5, 4'b0000);
        rxhl(32'h81, 32'hA5);
        wr(IDX_FRAME_FORMAT_CONTROL, 32'h06);
        usdb_line_model_i.send(9'h15A, 4'b0000);
        usdb_line_model_i.send(9'h0C3, 4'b0000);
        rchk(IDX_RXL, 32'h5A, "rx_low");
        rchk(IDX_RXH, 32'h81, "rx_high");
        rchk(IDX_RXL, 32'hC3, "rx_low");
        rchk(IDX_RXH, 32'h80, "rx_high");
        wr(IDX_ENABLE_AND_RECEIVE_MODE, 32'h86);
        wr(IDX_FRAME_FORMAT_CONTROL, 32'h13);
        usdb_line_model_i.send(9'h0AA, 4'b0010);
        usdb_line_model_i.send(9'h055, 4'b0001);
        rxhl(32'h82, 32'hAA);
        rxhl(32'h81, 32'h55);
        wr(IDX_ENABLE_AND_RECEIVE_MODE, 32'h80);
        wr(IDX_FRAME_FORMAT_CONTROL, 32'hC3);
        usdb_line_model_i.send(9'h066, 4'b1100);
        rxhl(32'h80, 32'h66);
        // Flush with errors pending
        wr(IDX_FRAME_FORMAT_CONTROL, 32'h13);
        usdb_line_model_i.send(9'h001, 4'b1100);
        usdb_line_model_i.send(9'h002, 4'b0000);
        usdb_line_model_i.send(9'h003, 4'b0000);
        usdb_line_model_i.start();
        wr(IDX_ENABLE_AND_RECEIVE_MODE, 32'h00);
        rchk(IDX_RXH, 32'h00, "rx_high");
        usdb_line_model_i.send(9'h007, 4'b0000);
        rchk(IDX_STAT, 32'h20, "status");
        // Transmit with a stalled shifter
        wr(IDX_ICLR, 32'hF);
        usdb_line_model_i.hold_busy <= 1'b1;
        wr(IDX_ENABLE_AND_RECEIVE_MODE, 32'h40);
        wr(IDX_FRAME_FORMAT_CONTROL, 32'h03);
        wr(IDX_TXL, 32'h5A);
        rchk(IDX_STAT, 32'h00, "status");
        wr(IDX_TXL, 32'h11);
        rchk(IDX_ISTAT, 32'h08, "istat");
        usdb_line_model_i.hold_busy <= 1'b0;
        wait_tx(1);
        chk("tx_data", 32'h05A, usdb_line_model_i.last_tx);
        wr(IDX_FRAME_FORMAT_CONTROL, 32'h02);
        wr(IDX_TXL, 32'hFF);
        wait_tx(2);
        chk("tx_data", 32'h07F, usdb_line_model_i.last_tx);
        wr(IDX_FRAME_FORMAT_CONTROL, 32'h07);
        wr(IDX_TXH, 32'h1);
        wr(IDX_TXL, 32'h22);
        wait_tx(3);
        chk("tx_data", 32'h122, usdb_line_model_i.last_tx);
        wr(IDX_FRAME_FORMAT_CONTROL, 32'h06);
        wr(IDX_TXL, 32'h33);
        wr(IDX_TXH, 32'h1);
        wait_tx(4);
        chk("tx_data", 32'h133, usdb_line_model_i.last_tx);
        rchk(IDX_ISTAT, 32'h0C, "istat");
        // Interrupt raised, masked and cleared
        wr(IDX_ICLR, 32'hF);
        wr(IDX_IEN, 32'h1);
        wr(IDX_ENABLE_AND_RECEIVE_MODE, 32'h80);
        chk("irq", 32'h0, irq);
        usdb_line_model_i.send(9'h044, 4'b0000);
        repeat (3) @(posedge aclk);
        chk("irq", 32'h1, irq);
        wr(IDX_IEN, 32'h0);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, irq);
        wr(IDX_IEN, 32'h1);
        rchk(IDX_RXL, 32'h44, "rx_low");
        wr(IDX_ICLR, 32'h1);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h0, irq);
        rchk(IDX_ISTAT, 32'h00, "istat");
        test_done();
    end
endmodule
